// file: hdl/cis_sequencer.v
// interrupt arbitration and entry/return sequencing
`timescale 1ns/1ps
`include "cis_defs.vh"
module cis_sequencer #(
	parameter N_SRC   = 8,              // sources, vector index 1..N_SRC
	parameter PC_W    = 12,             // program counter width
	parameter FLAG_MASK = 8'hFF         // 1 = flag-type source, 0 = level-type
) (
	input  wire              ref_clk,        // cpu clock
	input  wire              arst_n,         // async reset, active low
	input  wire [N_SRC-1:0]  src_event,      // flag-type event pulses
	input  wire [N_SRC-1:0]  src_level,      // level-type conditions
	input  wire              instr_boundary, // current instruction completes this cycle
	input  wire              instr_sei,      // boundary instruction sets global enable
	input  wire              instr_cli,      // boundary instruction clears global enable
	input  wire              instr_return_from_handler_instr,     // return-from-handler issued
	input  wire              sleeping,       // core asleep
	input  wire [PC_W-1:0]   next_pc,        // return address to push
	input  wire [7:0]        status_in,      // alu flags bits 6:0
	input  wire [3:0]        reg_addr,       // register address
	input  wire [7:0]        reg_wdata,      // register write data
	input  wire              reg_wr,         // register write strobe
	input  wire              reg_rd,         // register read strobe
	output reg  [7:0]        reg_rdata,      // read data, cycle after strobe
	output wire              irq_take,       // request accepted at this boundary
	output reg  [PC_W-1:0]   vector_addr_q,  // vector address being entered
	output reg               vector_valid_q, // pulse: vector reached, fetch there
	output reg               busy_q,         // entry or return in progress
	output reg  [15:0]       sp_q,           // stack pointer
	output reg               push_we_q,      // pulse: stack byte write
	output reg  [15:0]       push_addr_q,    // stack byte address
	output reg  [7:0]        push_data_q,    // stack byte data
	output reg               pop_re_q,       // pulse: stack byte read
	output reg  [15:0]       pop_addr_q,     // stack byte read address
	input  wire [7:0]        pop_data,       // stack byte read data, next cycle
	output reg  [PC_W-1:0]   ret_pc_q,       // popped return address
	output reg               ret_valid_q,    // pulse: return address ready
	output wire [7:0]        core_status_flags // status flags, gie in bit 7
);
	localparam ST_IDLE  = 2'd0;
	localparam ST_ENTRY = 2'd1;
	localparam ST_RET   = 2'd2;
	// cycle counts cut to the counter width on purpose
	localparam [3:0]  CNT_ENTRY   = `CIS_ENTRY_CYC - 1;
	localparam [3:0]  CNT_WAKE    = `CIS_ENTRY_CYC + `CIS_WAKE_EXTRA_CYC - 1;
	localparam [3:0]  CNT_RET_SP  = `CIS_RETURN_CYC - 2;
	localparam [3:0]  CNT_RET_END = `CIS_RETURN_CYC - 1;
	localparam [15:0] SP_STEP     = `CIS_SP_STEP;

	reg [1:0]        state_q;
	reg [3:0]        cnt_q;
	reg              gie_q;
	reg              hold_q;       // one-instruction guard after return or sei
	reg [N_SRC-1:0]  flag_q;
	reg [N_SRC-1:0]  en_q;
	reg [N_SRC-1:0]  ack;
	reg [PC_W-1:0]   sel_idx;
	reg [PC_W-1:0]   ret_pc_d;
	wire [N_SRC-1:0] pend;
	integer          i;
	// zero-extended register views, low byte read back
	wire [N_SRC+7:0] flag_x  = {8'h00, flag_q};
	wire [N_SRC+7:0] en_x    = {8'h00, en_q};
	wire [N_SRC+7:0] level_x = {8'h00, src_level};

	// status flags are passed through; nothing saved on entry or return
	assign core_status_flags = {gie_q, status_in[6:0]};

	// pending requests: latched flags or present levels, gated by enables
	genvar g;
	generate
		for (g = 0; g < N_SRC; g = g + 1) begin : g_pend
			assign pend[g] = en_q[g] & (FLAG_MASK[g] ? flag_q[g] : src_level[g]);
		end
	endgenerate

	// lowest index wins, vector = index + 1 (reset owns zero)
	always @* begin
		sel_idx = {PC_W{1'b0}};
		ack = {N_SRC{1'b0}};
		for (i = N_SRC - 1; i >= 0; i = i - 1) begin
			if (pend[i]) begin
				sel_idx = i[PC_W-1:0] + 1'b1;
				ack = {N_SRC{1'b0}};
				ack[i] = 1'b1;
			end
		end
	end

	// accept only at a boundary, with gie set, not cleared now, no guard
	assign irq_take = (state_q == ST_IDLE) & instr_boundary & gie_q & ~instr_cli & ~hold_q & ~instr_return_from_handler_instr
		& (|pend);

	// flags: set wins over software clear and hardware acknowledge
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			flag_q <= {N_SRC{1'b0}};
		end else begin
			flag_q <= (flag_q & ~((reg_wr && reg_addr == `CIS_ADDR_FLAG_CLR) ? reg_wdata[N_SRC-1:0] : {N_SRC{1'b0}})
				& ~(irq_take ? ack : {N_SRC{1'b0}})) | (src_event & FLAG_MASK[N_SRC-1:0]);
		end
	end

	// return address assembled from popped bytes: high byte sits on top
	always @* begin
		ret_pc_d = ret_pc_q;
		if (state_q == ST_RET && cnt_q == 4'd2)
			ret_pc_d = {pop_data[PC_W-9:0], ret_pc_q[7:0]};
		else if (state_q == ST_RET && cnt_q == 4'd3)
			ret_pc_d = {ret_pc_q[PC_W-1:8], pop_data};
	end

	// sequencer
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q        <= ST_IDLE;
			cnt_q          <= 4'd0;
			gie_q          <= 1'b0;
			hold_q         <= 1'b0;
			en_q           <= {N_SRC{1'b0}};
			sp_q           <= `CIS_SP_RESET;
			vector_addr_q  <= {PC_W{1'b0}};
			vector_valid_q <= 1'b0;
			busy_q         <= 1'b0;
			push_we_q      <= 1'b0;
			push_addr_q    <= 16'h0000;
			push_data_q    <= 8'h00;
			pop_re_q       <= 1'b0;
			pop_addr_q     <= 16'h0000;
			ret_pc_q       <= {PC_W{1'b0}};
			ret_valid_q    <= 1'b0;
		end else begin
			vector_valid_q <= 1'b0;
			ret_valid_q    <= 1'b0;
			push_we_q      <= 1'b0;
			pop_re_q       <= 1'b0;
			ret_pc_q       <= ret_pc_d;
			if (instr_boundary)
				hold_q <= 1'b0;
			// software register writes
			if (reg_wr) begin
				case (reg_addr)
					`CIS_ADDR_ENABLE: en_q <= reg_wdata[N_SRC-1:0];
					`CIS_ADDR_STATUS: begin
						gie_q <= reg_wdata[`CIS_GIE_BIT];
						if (reg_wdata[`CIS_GIE_BIT] && !gie_q)
							hold_q <= 1'b1;
					end
					`CIS_ADDR_SP_LO: sp_q[7:0] <= reg_wdata;
					`CIS_ADDR_SP_HI: sp_q[15:8] <= reg_wdata;
					default: ;
				endcase
			end
			if (instr_boundary && instr_cli)
				gie_q <= 1'b0;
			if (instr_boundary && instr_sei && !gie_q)
				hold_q <= 1'b1;
			if (instr_boundary && instr_sei)
				gie_q <= 1'b1;
			case (state_q)
				ST_IDLE: begin
					if (irq_take) begin
						state_q       <= ST_ENTRY;
						busy_q        <= 1'b1;
						gie_q         <= 1'b0;
						vector_addr_q <= sel_idx;
						cnt_q         <= sleeping ? CNT_WAKE : CNT_ENTRY;
						push_we_q     <= 1'b1;
						push_addr_q   <= sp_q;
						push_data_q   <= next_pc[7:0];
					end else if (instr_return_from_handler_instr) begin
						state_q    <= ST_RET;
						busy_q     <= 1'b1;
						cnt_q      <= 4'd1;
						pop_re_q   <= 1'b1;
						pop_addr_q <= sp_q + 16'd1;
					end
				end
				ST_ENTRY: begin
					// high byte only right after the low byte push, once per entry
					if (push_we_q && push_addr_q == sp_q) begin
						push_we_q   <= 1'b1;
						push_addr_q <= sp_q - 16'd1;
						push_data_q <= {{(16 - PC_W){1'b0}}, next_pc[PC_W-1:8]};
						sp_q        <= sp_q - SP_STEP;
					end
					if (cnt_q == 4'd1) begin
						state_q        <= ST_IDLE;
						busy_q         <= 1'b0;
						vector_valid_q <= 1'b1;
					end
					cnt_q <= cnt_q - 4'd1;
				end
				ST_RET: begin
					if (cnt_q == 4'd1) begin
						pop_re_q   <= 1'b1;
						pop_addr_q <= sp_q + SP_STEP;
					end
					if (cnt_q == CNT_RET_SP) begin
						sp_q   <= sp_q + SP_STEP;
						gie_q  <= 1'b1;
					end
					if (cnt_q == CNT_RET_END) begin
						state_q     <= ST_IDLE;
						busy_q      <= 1'b0;
						hold_q      <= 1'b1;
						ret_valid_q <= 1'b1;
						cnt_q       <= 4'd0;
					end else begin
						cnt_q <= cnt_q + 4'd1;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// register reads, data one cycle after the strobe
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`CIS_ADDR_FLAG:   reg_rdata <= flag_x[7:0];
				`CIS_ADDR_ENABLE: reg_rdata <= en_x[7:0];
				`CIS_ADDR_STATUS: reg_rdata <= {gie_q, status_in[6:0]};
				`CIS_ADDR_SP_LO:  reg_rdata <= sp_q[7:0];
				`CIS_ADDR_SP_HI:  reg_rdata <= sp_q[15:8];
				`CIS_ADDR_LEVEL:  reg_rdata <= level_x[7:0];
				default:          reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule // cis_sequencer

// file: hdl/cis_defs.vh
// constants for the cpu interrupt sequencer
`ifndef CIS_DEFS_VH
`define CIS_DEFS_VH
`define CIS_GIE_BIT        7
`define CIS_ENTRY_CYC      4
`define CIS_WAKE_EXTRA_CYC 4
`define CIS_RETURN_CYC     4
`define CIS_JUMP_CYC       3
`define CIS_SP_STEP        2
`define CIS_SP_RESET       16'h025F
`define CIS_ADDR_FLAG_CLR  4'h0
`define CIS_ADDR_FLAG      4'h1
`define CIS_ADDR_ENABLE    4'h2
`define CIS_ADDR_STATUS    4'h3
`define CIS_ADDR_SP_LO     4'h4
`define CIS_ADDR_SP_HI     4'h5
`define CIS_ADDR_LEVEL     4'h6
`endif

// file: sim/cis_seq_chk_assertions.sv
// port checker for the interrupt sequencer
`timescale 1ns/1ps
module cis_seq_chk #(parameter N_SRC = 8, parameter PC_W = 12) (
	input wire            ref_clk, arst_n, instr_boundary, instr_cli, instr_return_from_handler_instr, sleeping, // core side
	input wire            irq_take, vector_valid_q, busy_q, push_we_q, pop_re_q, ret_valid_q, // outputs
	input wire [7:0]      status_in, core_status_flags, // status path
	input wire [PC_W-1:0] vector_addr_q, // vector entered
	input wire [15:0]     sp_q, push_addr_q, pop_addr_q // stack side
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// two byte push at sp and sp-1, two byte pop above it
	sequence s_push;
		push_we_q && push_addr_q == $past(sp_q) ##1 push_we_q && push_addr_q == $past(sp_q, 2) - 16'h1;
	endsequence
	sequence s_pop;
		pop_re_q && pop_addr_q == $past(sp_q) + 16'h1 ##1 pop_re_q && pop_addr_q == $past(sp_q, 2) + 16'h2;
	endsequence
	AST_GIE_OFF: assert property (irq_take |=> !core_status_flags[7]) else $error("gie kept after take");
	AST_TAKE_OK: assert property (irq_take |-> core_status_flags[7] && instr_boundary && !instr_cli && !busy_q)
		else $error("take without permission");
	AST_ENTRY: assert property (irq_take && !sleeping |-> ##4 vector_valid_q) else $error("entry not 4");
	AST_WAKE: assert property (irq_take && sleeping |-> ##8 vector_valid_q) else $error("wake entry not 8");
	AST_PUSH: assert property (irq_take |=> s_push ##1 sp_q == $past(sp_q, 3) - 16'h2) else $error("push bad");
	AST_POP: assert property (instr_return_from_handler_instr |=> s_pop) else $error("pop bad");
	AST_RET: assert property (instr_return_from_handler_instr |-> ##4 ret_valid_q && core_status_flags[7] && sp_q == $past(sp_q, 4) + 16'h2)
		else $error("return bad");
	AST_STATUS: assert property (core_status_flags[6:0] == status_in[6:0]) else $error("status altered");
	AST_RET_GUARD: assert property (ret_valid_q |-> !irq_take) else $error("take right after return");
	AST_VEC: assert property (vector_valid_q |-> vector_addr_q != 0 && vector_addr_q <= N_SRC)
		else $error("vector out of range");
endmodule // cis_seq_chk
bind cis_sequencer cis_seq_chk #(.N_SRC(N_SRC), .PC_W(PC_W)) chk_u (.ref_clk(ref_clk), .arst_n(arst_n),
	.instr_boundary(instr_boundary), .instr_cli(instr_cli), .instr_return_from_handler_instr(instr_return_from_handler_instr), .sleeping(sleeping),
	.irq_take(irq_take), .vector_valid_q(vector_valid_q), .busy_q(busy_q), .push_we_q(push_we_q),
	.pop_re_q(pop_re_q), .ret_valid_q(ret_valid_q), .status_in(status_in), .core_status_flags(core_status_flags),
	.vector_addr_q(vector_addr_q), .sp_q(sp_q), .push_addr_q(push_addr_q), .pop_addr_q(pop_addr_q));

// file: sim/cis_stack_mdl.sv
// stack memory model on the far side
`timescale 1ns/1ps
module cis_stack_mdl (
	input wire        ref_clk, push_we_q, pop_re_q, // clock and byte strobes
	input wire [15:0] push_addr_q, pop_addr_q, // byte addresses
	input wire [7:0]  push_data_q, // byte written
	output reg [7:0]  pop_data // byte read, next cycle
);
	reg [7:0] mem_q [0:1023];
	initial pop_data = 8'h00;
	// stale read data toggles so it never looks valid
	always @(posedge ref_clk) begin
		if (push_we_q) mem_q[push_addr_q[9:0]] <= push_data_q;
		pop_data <= pop_re_q ? mem_q[pop_addr_q[9:0]] : ~pop_data;
	end
endmodule // cis_stack_mdl

// file: sim/tb.sv
// self-checking bench for the interrupt sequencer
`timescale 1ns/1ps
module tb;
	reg         ref_clk, arst_n, instr_boundary, instr_sei, instr_cli, instr_return_from_handler_instr, sleeping, reg_wr, reg_rd, rd_seen;
	reg  [7:0]  src_event, src_level, status_in, reg_wdata, rnd;
	reg  [3:0]  reg_addr;
	reg  [11:0] next_pc, pc_a;
	wire [7:0]  reg_rdata, core_status_flags, pop_data, push_data_q;
	wire [11:0] vector_addr_q, ret_pc_q;
	wire        irq_take, vector_valid_q, busy_q, push_we_q, pop_re_q, ret_valid_q;
	wire [15:0] sp_q, push_addr_q, pop_addr_q;
	reg  [15:0] exp_q [$];
	integer     err_total = 0, checks_done = 0;
	cis_sequencer #(.N_SRC(8), .PC_W(12), .FLAG_MASK(8'h7F)) dut_u (.ref_clk(ref_clk), .arst_n(arst_n),
		.src_event(src_event), .src_level(src_level), .instr_boundary(instr_boundary), .instr_sei(instr_sei),
		.instr_cli(instr_cli), .instr_return_from_handler_instr(instr_return_from_handler_instr), .sleeping(sleeping), .next_pc(next_pc),
		.status_in(status_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq_take(irq_take), .vector_addr_q(vector_addr_q), .vector_valid_q(vector_valid_q),
		.busy_q(busy_q), .sp_q(sp_q), .push_we_q(push_we_q), .push_addr_q(push_addr_q), .push_data_q(push_data_q),
		.pop_re_q(pop_re_q), .pop_addr_q(pop_addr_q), .pop_data(pop_data), .ret_pc_q(ret_pc_q),
		.ret_valid_q(ret_valid_q), .core_status_flags(core_status_flags));
	cis_stack_mdl stk_u (.ref_clk(ref_clk), .push_we_q(push_we_q), .pop_re_q(pop_re_q), .push_addr_q(push_addr_q),
		.pop_addr_q(pop_addr_q), .push_data_q(push_data_q), .pop_data(pop_data));
	function [7:0] lfsr(input [7:0] v);
		lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task chk(input [63:0] nm, input [15:0] seen, input [15:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			err_total = err_total + 1;
			$display("ERROR %0s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task finish_test;
		if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// one-cycle register strobes
	task wr(input [3:0] a, input [7:0] d);
		@(posedge ref_clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
		@(posedge ref_clk); reg_wr <= 1'b0;
	endtask
	task rd(input [3:0] a, input [7:0] e);
		@(posedge ref_clk); reg_addr <= a; reg_rd <= 1'b1; exp_q.push_back({8'h00, e});
		@(posedge ref_clk); reg_rd <= 1'b0;
	endtask
	// one instruction boundary carrying sei, cli, return_from_handler_instr and source events
	task drv(input [2:0] k, input [7:0] m);
		@(posedge ref_clk); {instr_sei, instr_cli, instr_return_from_handler_instr} <= k; src_event <= m;
		@(posedge ref_clk); {instr_sei, instr_cli, instr_return_from_handler_instr} <= 3'b000; src_event <= 8'h00;
	endtask
	task wt;
		repeat (12) begin
			@(posedge ref_clk); #1;
			if (vector_valid_q === 1'b1 || ret_valid_q === 1'b1) break;
		end
	endtask
	// results taken off the queue as they appear
	always @(posedge ref_clk) begin
		if ((rd_seen || vector_valid_q || ret_valid_q) && exp_q.size() == 0) chk("spurious", 16'h1, 16'h0);
		else if (rd_seen) chk("rdata", {8'h00, reg_rdata}, exp_q.pop_front());
		else if (vector_valid_q) chk("vector", {4'h0, vector_addr_q}, exp_q.pop_front());
		else if (ret_valid_q) chk("retpc", {4'h0, ret_pc_q}, exp_q.pop_front());
		rd_seen <= reg_rd;
	end
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	initial begin
		#20000; err_total = err_total + 1; finish_test;
	end
	initial begin
		{arst_n, instr_sei, instr_cli, instr_return_from_handler_instr, sleeping, reg_wr, reg_rd, rd_seen} = 8'h00;
		instr_boundary = 1'b1; src_event = 8'h00; src_level = 8'h00; reg_addr = 4'h0; reg_wdata = 8'h00;
		rnd = lfsr(8'h39); status_in = rnd; rnd = lfsr(rnd); next_pc = {rnd[3:0], lfsr(rnd)};
		repeat (10) @(posedge ref_clk);
		arst_n <= 1'b1;
		rd(4'h4, 8'h5F); rd(4'h5, 8'h02); rd(4'h9, 8'h00);
		rd(4'h3, {1'b0, status_in[6:0]});
		drv(3'b000, 8'h26); wr(4'h0, 8'h00); rd(4'h1, 8'h26);
		wr(4'h0, 8'h02); rd(4'h1, 8'h24);
		wr(4'h2, 8'hFF); rd(4'h2, 8'hFF);
		exp_q.push_back(16'h0003); drv(3'b100, 8'h00); wt;
		rd(4'h1, 8'h20);
		pc_a = next_pc; rnd = lfsr(rnd); next_pc <= {rnd[3:0], lfsr(rnd)};
		exp_q.push_back({4'h0, pc_a}); exp_q.push_back(16'h0006); drv(3'b001, 8'h00); wt; wt;
		exp_q.push_back({4'h0, next_pc}); drv(3'b001, 8'h00); wt;
		drv(3'b010, 8'h01); rd(4'h1, 8'h01); wr(4'h0, 8'h01);
		@(posedge ref_clk); src_level <= 8'h80;
		repeat (3) @(posedge ref_clk);
		src_level <= 8'h00; drv(3'b100, 8'h00);
		repeat (6) @(posedge ref_clk);
		exp_q.push_back(16'h0008); sleeping <= 1'b1; src_level <= 8'h80; instr_boundary <= 1'b0;
		rnd = lfsr(rnd); status_in <= rnd;
		repeat (3) @(posedge ref_clk);
		#1 chk("busy", {15'h0000, busy_q}, 16'h0000);
		@(posedge ref_clk); instr_boundary <= 1'b1; wt;
		src_level <= 8'h00; sleeping <= 1'b0;
		rd(4'h3, {1'b0, status_in[6:0]});
		exp_q.push_back({4'h0, next_pc}); drv(3'b001, 8'h00); wt;
		repeat (3) @(posedge ref_clk);
		finish_test;
	end
endmodule // tb
